/* sdc_decimator.sv */
`timescale 1ns/1ps
// Function
// [RULE1] Each channel runs a third-order sinc decimator followed by a first-order averager.
// [RULE2] The averager is bypassed with ratio one unless total oversampling exceeds 512.
// [RULE3] Selector codes 0 to 4 give ratios 32 to 512 unaveraged, codes 5 to 7 average 2, 4, 8.
// [RULE4] Resolution is 17, 20, 23 bits at totals 32, 64, 128 and 24 bits from 256 up.
// [RULE5] Resolution never exceeds 24 bits.
// [RULE6] The first result comes after three ratios plus (averaging minus one) ratios of samples.
// [RULE7] Unsettled filter outputs are dropped so every ready pulse marks settled data.
// [RULE8] Later ready pulses follow one output-rate period apart.
// [RULE9] Input-to-output latency equals the settling time.
// [RULE10] Results are 24-bit two's complement words, most significant bit first.
// [RULE11] Lower resolutions are left-justified with zero low bits.
// [RULE12] All channels share the one resolution from the common selector.
// [RULE13] Overrange clamps to the largest positive or most negative code.
// [RULE14] A 2-bit width selector reformats results to 16, 24 or 32 bits, 01 meaning 24.
// [RULE15] The output rate is the sample rate over total oversampling, common to all channels.
module sdc_decimator #(
	parameter int NUM_CH = 4,
	parameter int ACC_W = 34
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// modulator stream
	input wire logic sample_valid,
	input wire logic [NUM_CH-1:0] mod_bits,
	// configuration
	input wire logic [2:0] oversampling_select,
	input wire logic [1:0] width_select,
	// results
	output logic data_ready,
	output logic [NUM_CH-1:0][31:0] result
);
	localparam int WIDE_W = ACC_W + sdc_pkg::FULL_SCALE_LOG2;

	logic [2:0] cfg_ff, nxt_cfg;
	logic [8:0] phase_ff, nxt_phase;
	logic [1:0] settle_ff, nxt_settle;
	logic [2:0] avg_cnt_ff, nxt_avg_cnt;
	logic dr_ff, nxt_dr;
	logic [NUM_CH-1:0][31:0] res_ff, nxt_res;
	logic [NUM_CH-1:0][23:0] r24;
	logic [NUM_CH-1:0] pos_ovf;
	logic signed [NUM_CH-1:0][ACC_W-1:0] sums;
	logic signed [WIDE_W-1:0] wide;
	logic [3:0] k, a;
	logic [4:0] sh;
	logic [8:0] r_last;
	logic [2:0] a_last;
	logic [23:0] mask;
	logic restart, dec, settled, take, emit;

	////////////////////////////////////////////////////////////////////////////////
	// shared timing
	always_comb begin
		restart = oversampling_select != cfg_ff;
		k = 4'(sdc_pkg::third_log2(cfg_ff)); // see [RULE3]
		a = 4'(sdc_pkg::avg_log2(cfg_ff)); // see [RULE2]
		r_last = 9'h1ff >> (4'(sdc_pkg::THIRD_LOG2_MAX) - k);
		a_last = 3'h7 >> (4'(sdc_pkg::AVG_LOG2_MAX) - a);
		dec = sample_valid && !restart && phase_ff == r_last;
		settled = settle_ff == sdc_pkg::SETTLE_DISCARD; // see [RULE7]
		take = dec && settled;
		emit = take && avg_cnt_ff == a_last; // see [RULE15]
		nxt_cfg = oversampling_select;
		nxt_phase = phase_ff;
		nxt_settle = settle_ff;
		nxt_avg_cnt = avg_cnt_ff;
		if (restart) begin
			nxt_phase = '0;
			nxt_settle = '0;
			nxt_avg_cnt = '0;
		end else begin
			if (sample_valid) begin
				nxt_phase = dec ? 9'h0 : phase_ff + 9'h1; // see [RULE8]
			end
			if (dec && !settled) begin // see [RULE6]
				nxt_settle = settle_ff + 2'h1;
			end
			if (take) begin
				nxt_avg_cnt = emit ? 3'h0 : avg_cnt_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= '0;
			phase_ff <= '0;
			settle_ff <= '0;
			avg_cnt_ff <= '0;
		end else begin
			cfg_ff <= nxt_cfg;
			phase_ff <= nxt_phase;
			settle_ff <= nxt_settle;
			avg_cnt_ff <= nxt_avg_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel filters
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		sdc_sinc_channel #(
			.ACC_W(ACC_W)
		) u_filt (
			.core_clk(core_clk),
			.rst(rst),
			.clear(restart),
			.sample_vld(sample_valid && !restart),
			.dec_stb(dec),
			.avg_take(take),
			.avg_first(avg_cnt_ff == 3'h0),
			.bit_in(mod_bits[ch]),
			.avg_sum(sums[ch])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// scaling, clamping, formatting
	always_comb begin
		sh = 5'(k) * 5'h3 + 5'(a);
		mask = sdc_pkg::MASK_ALL
			<< (5'(sdc_pkg::RES_MAX) - 5'(sdc_pkg::res_bits(cfg_ff))); // see [RULE12]
		nxt_dr = emit;
		nxt_res = res_ff;
		wide = '0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			wide = $signed({sums[ch], 23'h0}) >>> sh;
			pos_ovf[ch] = wide > $signed(WIDE_W'(sdc_pkg::CODE_MAX_POS));
			if (pos_ovf[ch]) begin
				r24[ch] = sdc_pkg::CODE_MAX_POS; // see [RULE13]
			end else if (wide < -$signed(WIDE_W'(sdc_pkg::CODE_MAX_NEG))) begin
				r24[ch] = sdc_pkg::CODE_MAX_NEG; // see [RULE13]
			end else begin
				r24[ch] = wide[23:0]; // see [RULE10] [RULE5]
			end
			r24[ch] = r24[ch] & mask; // see [RULE4] [RULE11]
			if (emit) begin // see [RULE9]
				case (width_select) // see [RULE14]
					sdc_pkg::WIDTH_16: nxt_res[ch] = {16'h0, r24[ch][23:8]};
					sdc_pkg::WIDTH_24: nxt_res[ch] = {8'h0, r24[ch]};
					sdc_pkg::WIDTH_32_PAD: nxt_res[ch] = {r24[ch], 8'h0};
					default: nxt_res[ch] = {{8{r24[ch][23]}}, r24[ch]};
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dr_ff <= 1'b0;
			res_ff <= '0;
		end else begin
			dr_ff <= nxt_dr;
			res_ff <= nxt_res;
		end
	end

	assign data_ready = dr_ff;
	assign result = res_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checking helpers
	logic [13:0] samp_cnt_ff, gap_ff, lastgap_ff;
	logic seen_ff;
	logic [13:0] exp_settle, exp_total;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			samp_cnt_ff <= '0;
			gap_ff <= '0;
			lastgap_ff <= '0;
			seen_ff <= 1'b0;
		end else if (restart) begin
			samp_cnt_ff <= '0;
			gap_ff <= '0;
			seen_ff <= 1'b0;
		end else begin
			if (sample_valid && samp_cnt_ff != 14'h3fff) begin
				samp_cnt_ff <= samp_cnt_ff + 14'h1;
			end
			gap_ff <= emit ? 14'h0 : gap_ff + 14'(sample_valid);
			if (emit) begin
				lastgap_ff <= gap_ff + 14'h1;
			end
			if (dr_ff) begin
				seen_ff <= 1'b1;
			end
		end
	end
	assign exp_settle = 14'((5'h1 << a) + 5'(sdc_pkg::SETTLE_EXTRA)) << k;
	assign exp_total = 14'h1 << (k + a);

	property p_first_settle;
		@(posedge core_clk) disable iff (rst) dr_ff && !seen_ff |-> samp_cnt_ff == exp_settle;
	endproperty
	a_first_settle: assert property (p_first_settle) else $error("first result off settling"); // see [RULE6]
	property p_period;
		@(posedge core_clk) disable iff (rst) dr_ff && seen_ff |-> lastgap_ff == exp_total;
	endproperty
	a_period: assert property (p_period) else $error("ready spacing wrong"); // see [RULE8]
	property p_settled_only;
		@(posedge core_clk) disable iff (rst) emit |-> settled
			##1 dr_ff && samp_cnt_ff >= exp_settle;
	endproperty
	a_settled_only: assert property (p_settled_only) else $error("unsettled result"); // see [RULE7]
	sequence s_ready;
		dr_ff;
	endsequence
	sequence s_quiet;
		!dr_ff [*8];
	endsequence
	property p_pulse;
		@(posedge core_clk) disable iff (rst) s_ready |=> s_quiet;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready pulses too close"); // see [RULE15]
	property p_bypass;
		@(posedge core_clk) disable iff (rst) cfg_ff <= sdc_pkg::SEL_LAST_PLAIN |-> a == 4'h0;
	endproperty
	a_bypass: assert property (p_bypass) else $error("averager not bypassed"); // see [RULE2]
	property p_ratio;
		@(posedge core_clk) disable iff (rst) cfg_ff > sdc_pkg::SEL_LAST_PLAIN |-> r_last == 9'h1ff;
	endproperty
	a_ratio: assert property (p_ratio) else $error("third-order ratio wrong"); // see [RULE3]
	property p_justify;
		@(posedge core_clk) disable iff (rst) emit && width_select == sdc_pkg::WIDTH_24
			|=> (res_ff[0][23:0] & ~$past(mask)) == 24'h0 && res_ff[0][31:24] == 8'h0;
	endproperty
	a_justify: assert property (p_justify) else $error("low bits not zero"); // see [RULE11]
	property p_clamp;
		@(posedge core_clk) disable iff (rst) emit && pos_ovf[0] && width_select == sdc_pkg::WIDTH_24
			|=> res_ff[0][23:0] == (sdc_pkg::CODE_MAX_POS & $past(mask));
	endproperty
	a_clamp: assert property (p_clamp) else $error("positive clamp wrong"); // see [RULE13]
endmodule : sdc_decimator

/* sdc_pkg.sv */
package sdc_pkg;
	// oversampling selector
	localparam logic [2:0] SEL_LAST_PLAIN = 3'h4;
	localparam int THIRD_LOG2_MIN = 5;
	localparam int THIRD_LOG2_MAX = 9;
	localparam int AVG_LOG2_MAX = 3;
	// resolution
	localparam int RES_MAX = 24;
	localparam int RES_OSR32 = 17;
	localparam int RES_OSR64 = 20;
	localparam int RES_OSR128 = 23;
	localparam int FULL_SCALE_LOG2 = 23;
	localparam logic [23:0] CODE_MAX_POS = 24'h7fffff;
	localparam logic [23:0] CODE_MAX_NEG = 24'h800000;
	localparam logic [23:0] MASK_ALL = 24'hffffff;
	// output width selector
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_24 = 2'h1;
	localparam logic [1:0] WIDTH_32_PAD = 2'h2;
	localparam logic [1:0] WIDTH_32_SEXT = 2'h3;
	// settling
	localparam logic [1:0] SETTLE_DISCARD = 2'h2;
	localparam int SETTLE_EXTRA = 2;

	function automatic int third_log2(input logic [2:0] sel);
		if (sel > SEL_LAST_PLAIN) begin
			return THIRD_LOG2_MAX;
		end
		return THIRD_LOG2_MIN + int'(sel);
	endfunction : third_log2

	function automatic int avg_log2(input logic [2:0] sel);
		if (sel > SEL_LAST_PLAIN) begin
			return int'(sel - SEL_LAST_PLAIN);
		end
		return 0;
	endfunction : avg_log2

	function automatic int res_bits(input logic [2:0] sel);
		case (sel)
			3'h0: return RES_OSR32;
			3'h1: return RES_OSR64;
			3'h2: return RES_OSR128;
			default: return RES_MAX;
		endcase
	endfunction : res_bits
endpackage : sdc_pkg

/* sdc_sinc_channel.sv */
`timescale 1ns/1ps
module sdc_sinc_channel #(
	parameter int ACC_W = 34
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control strobes
	input wire logic clear,
	input wire logic sample_vld,
	input wire logic dec_stb,
	input wire logic avg_take,
	input wire logic avg_first,
	// modulator bit
	input wire logic bit_in,
	// averaged sum
	output logic signed [ACC_W-1:0] avg_sum
);
	logic signed [ACC_W-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff, acc_ff;
	logic signed [ACC_W-1:0] nxt_i1, nxt_i2, nxt_i3, nxt_d1, nxt_d2, nxt_d3, nxt_acc;
	logic signed [ACC_W-1:0] x, c1, c2, c3;

	////////////////////////////////////////////////////////////////////////////////
	// integrators, combs, averaging
	always_comb begin
		x = bit_in ? ACC_W'(1) : '1;
		nxt_i1 = i1_ff;
		nxt_i2 = i2_ff;
		nxt_i3 = i3_ff;
		if (sample_vld) begin
			nxt_i1 = i1_ff + x;
			nxt_i2 = i2_ff + nxt_i1;
			nxt_i3 = i3_ff + nxt_i2;
		end
		c1 = nxt_i3 - d1_ff;
		c2 = c1 - d2_ff;
		c3 = c2 - d3_ff;
		nxt_d1 = d1_ff;
		nxt_d2 = d2_ff;
		nxt_d3 = d3_ff;
		if (dec_stb) begin // see [RULE1]
			nxt_d1 = nxt_i3;
			nxt_d2 = c1;
			nxt_d3 = c2;
		end
		nxt_acc = acc_ff;
		if (avg_take) begin // see [RULE1]
			nxt_acc = avg_first ? c3 : acc_ff + c3;
		end
		if (clear) begin
			nxt_i1 = '0;
			nxt_i2 = '0;
			nxt_i3 = '0;
			nxt_d1 = '0;
			nxt_d2 = '0;
			nxt_d3 = '0;
			nxt_acc = '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			i1_ff <= '0;
			i2_ff <= '0;
			i3_ff <= '0;
			d1_ff <= '0;
			d2_ff <= '0;
			d3_ff <= '0;
			acc_ff <= '0;
		end else begin
			i1_ff <= nxt_i1;
			i2_ff <= nxt_i2;
			i3_ff <= nxt_i3;
			d1_ff <= nxt_d1;
			d2_ff <= nxt_d2;
			d3_ff <= nxt_d3;
			acc_ff <= nxt_acc;
		end
	end

	assign avg_sum = nxt_acc;
endmodule : sdc_sinc_channel

/* sdc_mod_model.sv */
`timescale 1ns/1ps
module sdc_mod_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic slow,
	// bitstream
	output logic sample_valid,
	output logic [3:0] mod_bits
);
	logic phase_ff;
	logic alt_ff;
	logic nxt_phase;
	logic nxt_alt;
	////////////////////////////////////////////////////////////////////////
	// slow mode offers a sample every other cycle
	always_comb begin
		nxt_phase = ~phase_ff;
		nxt_alt = sample_valid ? ~alt_ff : alt_ff;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_ff <= 1'b0;
			alt_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			alt_ff <= nxt_alt;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// ch0 and ch3 all ones, ch1 all zeros, ch2 alternating; idle lines wander
	assign sample_valid = run & (~slow | phase_ff);
	assign mod_bits = sample_valid ? {1'b1, alt_ff, 1'b0, 1'b1}
		: {alt_ff, phase_ff, ~alt_ff, ~phase_ff};
endmodule : sdc_mod_model

/* sdc_decimator_test.sv */
`timescale 1ns/1ps
module sdc_decimator_test;
	logic core_clk;
	logic rst;
	logic run;
	logic slow;
	logic sample_valid;
	logic [3:0] mod_bits;
	logic [2:0] oversampling_select;
	logic [1:0] width_select;
	logic data_ready;
	logic [3:0][31:0] result;
	int err_count;
	int compares;
	int carry;
	////////////////////////////////////////////////////////////////////////
	sdc_mod_model sdc_mod_model_i (.core_clk(core_clk), .rst(rst), .run(run), .slow(slow),
		.sample_valid(sample_valid), .mod_bits(mod_bits));
	sdc_decimator #(.NUM_CH(4), .ACC_W(34)) sdc_decimator_i (.core_clk(core_clk), .rst(rst),
		.sample_valid(sample_valid), .mod_bits(mod_bits),
		.oversampling_select(oversampling_select), .width_select(width_select),
		.data_ready(data_ready), .result(result));
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic finish_test;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] fmt(input logic [23:0] r, input logic [1:0] w);
		case (w)
			2'h0: return {16'h0, r[23:8]};
			2'h1: return {8'h0, r};
			2'h2: return {r, 8'h0};
			default: return {{8{r[23]}}, r};
		endcase
	endfunction : fmt
	function automatic logic [23:0] top_code(input logic [2:0] s);
		int res;
		res = (s == 3'h0) ? 17 : (s == 3'h1) ? 20 : (s == 3'h2) ? 23 : 24;
		return 24'h7fffff & (24'hffffff << (24 - res));
	endfunction : top_code
	////////////////////////////////////////////////////////////////////////
	// counts samples up to the next ready pulse; pulse-cycle sample opens next span
	task automatic wait_pulse(output int n);
		n = carry;
		for (int i = 0; i < 20000; i++) begin
			@(negedge core_clk);
			if (data_ready === 1'b1) begin
				carry = int'(sample_valid === 1'b1);
				return;
			end
			n += int'(sample_valid === 1'b1);
		end
		err_count++;
		$display("no ready pulse within limit");
	endtask : wait_pulse
	task automatic check_ch(input logic [2:0] s, input logic [1:0] w);
		check("result ch0", result[0], fmt(top_code(s), w));
		check("result ch1", result[1], fmt(24'h800000, w));
		check("result ch2", result[2], fmt(24'h000000, w));
		check("result ch3", result[3], fmt(top_code(s), w));
	endtask : check_ch
	task automatic run_sel(input logic [2:0] s, input logic sl);
		int r;
		int a;
		int n;
		r = (s > 3'h4) ? 512 : (32 << s);
		a = (s > 3'h4) ? (1 << (s - 3'h4)) : 1;
		@(posedge core_clk);
		run <= 1'b0;
		slow <= sl;
		oversampling_select <= s;
		repeat (3) @(posedge core_clk);
		carry = 0;
		run <= 1'b1;
		wait_pulse(n);
		check("settle samples", n, r * (a + 2));
		check_ch(s, 2'h1);
		wait_pulse(n);
		check("period samples", n, r * a);
		check_ch(s, 2'h1);
	endtask : run_sel
	task automatic test_widths;
		int n;
		for (int w = 0; w < 4; w++) begin
			@(posedge core_clk);
			width_select <= 2'(w);
			wait_pulse(n);
			check("width period", n, 32);
			check_ch(3'h0, 2'(w));
		end
		@(posedge core_clk);
		width_select <= 2'h1;
	endtask : test_widths
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(60000 * 20);
		err_count++;
		$display("watchdog expired");
		finish_test();
	end
	initial begin
		rst = 1'b1;
		run = 1'b0;
		slow = 1'b0;
		oversampling_select = 3'h0;
		width_select = 2'h1;
		err_count = 0;
		compares = 0;
		carry = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check("ready after reset", {31'h0, data_ready}, 32'h0);
		check("result after reset", result[0], 32'h0);
		run_sel(3'h0, 1'b0);
		test_widths();
		for (int s = 1; s < 8; s++) begin
			run_sel(3'(s), s == 2);
		end
		finish_test();
	end
endmodule : sdc_decimator_test
